// *** rtl/pdr_pkg.sv ***
// Purpose: Shared constants for the power-down and reset controller ends
// Assumes: One 100 MHz clock on both ends
// Notes:   Device register index is three bits, data is sixteen bits
package pdr_pkg;
  // Clock and times
  localparam int CLK_PERIOD_NS   = 10;
  localparam int STANDBY_NS      = 70;
  localparam int RECOVERY_NS     = 120;
  localparam int POR_HOLD_US     = 1000;
  localparam int WARM_WIDTH_NS   = 150;
  localparam int ABORT_LIMIT_US  = 25;
  // Least times round up except recovery; recovery and longest times round down
  localparam int STANDBY_CYCLES  = (STANDBY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOVERY_CYCLES = RECOVERY_NS / CLK_PERIOD_NS;
  localparam int POR_HOLD_CYCLES = (POR_HOLD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WARM_CYCLES     = (WARM_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ABORT_CYCLES    = (ABORT_LIMIT_US * 1000) / CLK_PERIOD_NS;
  localparam int APD_LIMIT       = 15;
  localparam int CFG_LOAD_CYCLES = 16;

  // Device register indices
  localparam logic [2:0] IDX_MODE_A   = 3'h0;
  localparam logic [2:0] IDX_MODE_C   = 3'h1;
  localparam logic [2:0] IDX_APD_CFG  = 3'h2;
  localparam logic [2:0] IDX_BUS_MODE = 3'h3;
  localparam logic [2:0] IDX_STATUS   = 3'h4;

  // Field positions
  localparam int A_APD_EN   = 1;
  localparam int A_LOW_PWR  = 3;
  localparam int A_CLK_AND  = 4;
  localparam int A_CLK_MC   = 5;
  localparam int CFG_POL    = 0;
  localparam int BM_CODE    = 3;
  localparam int BM_PERIPH  = 7;
  localparam int ST_PD      = 0;
  localparam int ST_BATT    = 1;
  localparam int ST_FBUSY   = 2;
  localparam int ST_VALID   = 3;
  localparam logic [15:0] MODE_C_MASK = 16'h007D;
  localparam logic [15:0] ZERO16      = 16'h0000;

  // Host register indices
  localparam logic [3:0] H_CMD    = 4'h8;
  localparam logic [3:0] H_STATUS = 4'h9;
  localparam logic [3:0] H_BUS    = 4'hA;
  localparam logic [3:0] H_ADDR   = 4'hB;
  localparam logic [3:0] H_SECT   = 4'hC;
  localparam int CMD_POR  = 0;
  localparam int CMD_WARM = 1;
  localparam int BUS_RUN  = 0;
  localparam int BUS_CS_N = 1;
  localparam int BUS_WRL  = 2;
  localparam int BUS_C1   = 3;
  localparam int BUS_C2   = 4;
  localparam int BUS_WRH  = 5;
  localparam logic [15:0] BUS_RESET = 16'h0002;
endpackage : pdr_pkg

// *** rtl/pdr_link_if.sv ***
// Purpose: Pins between the bus master and the power and reset device
// Assumes: Both ends on the same clock
// Notes:   Strobes named _n are active low
`timescale 1ns/100ps
interface pdr_link_if;
  logic        rst_req;
  logic        address_strobe_in;
  logic        chip_select_n;
  logic        write_strobe_low_n;
  logic        write_strobe_high_n;
  logic        bus_control_1;
  logic        bus_control_2;
  logic [7:0]  address_low;
  logic [7:0]  primary_sector_selects;
  logic [3:0]  secondary_sector_selects;
  logic [2:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic        power_down_flag;
  logic        battery_active_indicator;

  modport dev (
    input  rst_req, address_strobe_in, chip_select_n, write_strobe_low_n, write_strobe_high_n,
    input  bus_control_1, bus_control_2, address_low, primary_sector_selects, secondary_sector_selects,
    input  reg_addr, reg_wdata, reg_wr, reg_rd,
    output reg_rdata, power_down_flag, battery_active_indicator
  );
  modport host (
    output rst_req, address_strobe_in, chip_select_n, write_strobe_low_n, write_strobe_high_n,
    output bus_control_1, bus_control_2, address_low, primary_sector_selects, secondary_sector_selects,
    output reg_addr, reg_wdata, reg_wr, reg_rd,
    input  reg_rdata, power_down_flag, battery_active_indicator
  );
endinterface : pdr_link_if

// *** rtl/pdr_device.sv ***
// Purpose: Power-down, input blocking and reset sequencing of the device end
// Assumes: Bus master on the same clock; srst marks the supply coming up
// Notes:   Link reset is active high; first reset after srst is power-on reset
// Function
// - Mode A bit 3 selects low-power arrays
// - Low power: standby after 70 ns still
// - Chip select low enables memories
// - Mode A bits 4,5 block clock
// - Mode C bits block address and controls
// - Counter counts idle strobe, flags at 15
// - Master holds power-on reset at least 1 ms
// - No access within 120 ns after reset
// - Flash starts in read mode, idle
// - Power-on reset: selects low, write high
// - Warm reset pulse at least 150 ns
// - Outputs valid after configuration load
// - Reset aborts program or erase
// - Port states in reset and power-down
// - Power-on reset clears macrocells
// - Register reset behaviour per reset kind
// - Battery indicator follows supply comparator
// - Strobe, chip select or reset wakes
// - Power-down blocks inputs, deselects memories
// - Clock block leaves counter running
`timescale 1ns/100ps
module pdr_device #(
  parameter logic [15:0] BUS_MODE_CFG = 16'h00FF,
  parameter int          CFG_LOAD     = pdr_pkg::CFG_LOAD_CYCLES
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        srst,
  // Link to the bus master
  pdr_link_if.dev          link,
  // Supply comparator and flash engine
  input  wire logic        vcc_below_standby,
  input  wire logic        flash_done,
  // Logic array controls
  output logic             logic_low_power,
  output logic             logic_standby,
  output logic             clk_to_and_en,
  output logic             clk_to_mc_en,
  output logic [12:0]      logic_array_in,
  output logic             logic_outputs_valid,
  output logic             macrocell_clear,
  // Memory and flash
  output logic             memories_enable,
  output logic [11:0]      memory_selects,
  output logic             flash_busy,
  output logic             flash_abort,
  output logic [15:0]      bus_mode_out,
  // Port states
  output logic             gp_as_input,
  output logic             addr_out_oe,
  output logic             data_oe,
  output logic             periph_oe
);
  typedef enum logic [1:0] {PDR_PH_POR, PDR_PH_RECOV, PDR_PH_RUN} pdr_phase_t;

  initial begin
    if (CFG_LOAD < 1 || CFG_LOAD > 255) $error("CFG_LOAD out of range");
    if (pdr_pkg::ABORT_CYCLES < 1) $error("abort limit below one cycle");
  end

  pdr_phase_t  phase_r, phase_nxt;
  logic        por_r;
  logic [3:0]  recov_cnt_r;
  logic [7:0]  cfg_cnt_r;
  logic        cfg_done_r;
  logic [15:0] mode_a_r, mode_c_r, apd_cfg_r, bus_mode_r;
  logic [3:0]  apd_cnt_r;
  logic        pd_r;
  logic        strobe_q_r;
  logic [12:0] watch_q_r;
  logic [3:0]  still_cnt_r;
  logic        batt_s1_r, batt_s2_r;
  logic [15:0] rdata_r;

  // Reset phase decode
  wire in_reset = link.rst_req || (phase_r == PDR_PH_RECOV);
  wire running  = (phase_r == PDR_PH_RUN) && !link.rst_req;

  always_comb begin
    phase_nxt = phase_r;
    case (phase_r)
      PDR_PH_POR:   if (!link.rst_req && cfg_done_r) phase_nxt = PDR_PH_RECOV;
      PDR_PH_RECOV: if (link.rst_req) phase_nxt = PDR_PH_RECOV;
                    else if (recov_cnt_r == 4'h0) phase_nxt = PDR_PH_RUN;
      PDR_PH_RUN:   if (link.rst_req) phase_nxt = PDR_PH_RECOV;
      default:      phase_nxt = PDR_PH_POR;
    endcase
  end

  // Reset sequencing and configuration load
  always_ff @(posedge clock) begin
    if (srst) begin
      phase_r     <= PDR_PH_POR;
      por_r       <= 1'b1;
      recov_cnt_r <= 4'h0;
      cfg_cnt_r   <= 8'h00;
      cfg_done_r  <= 1'b0;
    end else begin
      phase_r <= phase_nxt;
      if (link.rst_req)
        recov_cnt_r <= 4'(pdr_pkg::RECOVERY_CYCLES - 1);
      else if (recov_cnt_r != 4'h0)
        recov_cnt_r <= recov_cnt_r - 4'h1;
      if (por_r && link.rst_req && !cfg_done_r) begin
        cfg_cnt_r <= cfg_cnt_r + 8'h01;
        if (cfg_cnt_r == 8'(CFG_LOAD - 1))
          cfg_done_r <= 1'b1;
      end
      if (phase_nxt == PDR_PH_RUN)
        por_r <= 1'b0;
    end
  end

  // Register access is refused in reset and in power-down
  wire acc_ok = running && !pd_r;
  wire wr_ok  = link.reg_wr && acc_ok;

  // Register file; only power-on reset clears the power mode registers
  always_ff @(posedge clock) begin
    if (srst) begin
      mode_a_r   <= pdr_pkg::ZERO16;
      mode_c_r   <= pdr_pkg::ZERO16;
      apd_cfg_r  <= pdr_pkg::ZERO16;
      bus_mode_r <= pdr_pkg::ZERO16;
    end else if (link.rst_req) begin
      if (por_r) begin
        mode_a_r  <= pdr_pkg::ZERO16;
        mode_c_r  <= pdr_pkg::ZERO16;
        apd_cfg_r <= pdr_pkg::ZERO16;
      end
      bus_mode_r <= BUS_MODE_CFG;
      bus_mode_r[pdr_pkg::BM_CODE]   <= 1'b0;
      bus_mode_r[pdr_pkg::BM_PERIPH] <= 1'b0;
    end else if (wr_ok) begin
      case (link.reg_addr)
        pdr_pkg::IDX_MODE_A:   mode_a_r   <= link.reg_wdata;
        pdr_pkg::IDX_MODE_C:   mode_c_r   <= link.reg_wdata & pdr_pkg::MODE_C_MASK;
        pdr_pkg::IDX_APD_CFG:  apd_cfg_r  <= link.reg_wdata;
        pdr_pkg::IDX_BUS_MODE: bus_mode_r <= link.reg_wdata;
        default: ;
      endcase
    end
  end

  // Automatic power-down counter
  wire strobe_edge = link.address_strobe_in != strobe_q_r;
  wire wake        = strobe_edge || !link.chip_select_n || link.rst_req;
  wire apd_en      = mode_a_r[pdr_pkg::A_APD_EN];
  wire strobe_idle = link.address_strobe_in == apd_cfg_r[pdr_pkg::CFG_POL];
  wire [3:0] apd_inc = (apd_cnt_r == 4'(pdr_pkg::APD_LIMIT)) ? apd_cnt_r : apd_cnt_r + 4'h1;

  // Runs on the raw clock, never on the gated array clocks
  always_ff @(posedge clock) begin
    if (srst) begin
      strobe_q_r <= 1'b0;
      apd_cnt_r  <= 4'h0;
      pd_r       <= 1'b0;
    end else begin
      strobe_q_r <= link.address_strobe_in;
      if (!apd_en || wake) begin
        apd_cnt_r <= 4'h0;
        pd_r      <= 1'b0;
      end else if (strobe_idle) begin
        apd_cnt_r <= apd_inc;
        if (apd_inc == 4'(pdr_pkg::APD_LIMIT))
          pd_r <= 1'b1;
      end
    end
  end

  // Array inputs: mode C bits and power-down both block
  wire [12:0] raw_in   = {link.write_strobe_high_n, link.address_strobe_in, link.bus_control_2,
                          link.bus_control_1, link.write_strobe_low_n, link.address_low};
  wire [12:0] blk_mask = {mode_c_r[6:2], {8{mode_c_r[0]}}};
  wire [12:0] arr_nxt  = pd_r ? watch_q_r : (raw_in & ~blk_mask);
  wire        low_pwr  = mode_a_r[pdr_pkg::A_LOW_PWR];
  wire        still    = (arr_nxt == watch_q_r);

  // Standby detector for the low-power arrays
  always_ff @(posedge clock) begin
    if (srst) begin
      watch_q_r   <= 13'h0000;
      still_cnt_r <= 4'h0;
    end else begin
      watch_q_r <= arr_nxt;
      if (!still || !low_pwr)
        still_cnt_r <= 4'h0;
      else if (still_cnt_r != 4'(pdr_pkg::STANDBY_CYCLES))
        still_cnt_r <= still_cnt_r + 4'h1;
    end
  end

  // Memory selection and flash engine
  wire [11:0] sel_in   = {link.secondary_sector_selects, link.primary_sector_selects};
  wire        mem_en   = !link.chip_select_n && !pd_r && running;
  wire        fl_start = mem_en && !link.write_strobe_low_n && (sel_in != 12'h000);
  wire        rd_cycle = mem_en && link.write_strobe_low_n && (sel_in != 12'h000);

  // Register read mux
  logic [15:0] rd_mux;
  always_comb begin
    case (link.reg_addr)
      pdr_pkg::IDX_MODE_A:   rd_mux = mode_a_r;
      pdr_pkg::IDX_MODE_C:   rd_mux = mode_c_r;
      pdr_pkg::IDX_APD_CFG:  rd_mux = apd_cfg_r;
      pdr_pkg::IDX_BUS_MODE: rd_mux = bus_mode_r;
      pdr_pkg::IDX_STATUS:   rd_mux = {12'h000, cfg_done_r, flash_busy, batt_s2_r, pd_r};
      default:               rd_mux = pdr_pkg::ZERO16;
    endcase
  end

  // Battery comparator sync; read data one cycle after the strobe
  always_ff @(posedge clock) begin
    if (srst) begin
      batt_s1_r <= 1'b0;
      batt_s2_r <= 1'b0;
      rdata_r   <= pdr_pkg::ZERO16;
    end else begin
      batt_s1_r <= vcc_below_standby;
      batt_s2_r <= batt_s1_r;
      rdata_r   <= (link.reg_rd && acc_ok) ? rd_mux : pdr_pkg::ZERO16;
    end
  end

  // Registered outputs
  always_ff @(posedge clock) begin
    if (srst) begin
      flash_busy          <= 1'b0;
      flash_abort         <= 1'b0;
      logic_low_power     <= 1'b0;
      logic_standby       <= 1'b0;
      clk_to_and_en       <= 1'b1;
      clk_to_mc_en        <= 1'b1;
      logic_array_in      <= 13'h0000;
      logic_outputs_valid <= 1'b0;
      macrocell_clear     <= 1'b1;
      memories_enable     <= 1'b0;
      memory_selects      <= 12'h000;
      bus_mode_out        <= pdr_pkg::ZERO16;
      gp_as_input         <= 1'b1;
      addr_out_oe         <= 1'b0;
      data_oe             <= 1'b0;
      periph_oe           <= 1'b0;
    end else begin
      flash_abort <= flash_busy && link.rst_req;
      if (link.rst_req)
        flash_busy <= 1'b0;
      else if (fl_start)
        flash_busy <= 1'b1;                                                 // Start wins over a same-cycle done
      else if (flash_done)
        flash_busy <= 1'b0;
      logic_low_power     <= low_pwr;
      logic_standby       <= low_pwr && still && (still_cnt_r == 4'(pdr_pkg::STANDBY_CYCLES));
      clk_to_and_en       <= !mode_a_r[pdr_pkg::A_CLK_AND];
      clk_to_mc_en        <= !mode_a_r[pdr_pkg::A_CLK_MC];
      logic_array_in      <= arr_nxt;
      logic_outputs_valid <= cfg_done_r;
      macrocell_clear     <= por_r && in_reset;
      memories_enable     <= mem_en;
      memory_selects      <= mem_en ? sel_in : 12'h000;
      bus_mode_out        <= bus_mode_r;
      gp_as_input         <= in_reset || phase_r == PDR_PH_POR;
      addr_out_oe         <= running && !pd_r;
      data_oe             <= rd_cycle;
      periph_oe           <= rd_cycle && bus_mode_r[pdr_pkg::BM_PERIPH];
    end
  end

  // Link outputs
  assign link.reg_rdata                = rdata_r;
  assign link.power_down_flag          = pd_r;
  assign link.battery_active_indicator = batt_s2_r;
endmodule : pdr_device

// *** rtl/pdr_host.sv ***
// Purpose: Bus master end: reset pulses, recovery wait and bus pin drive
// Assumes: Same clock as the device end
// Notes:   Indices 0 to 7 pass through to the device; its registers are 0 to 4
`timescale 1ns/100ps
module pdr_host #(
  parameter int POR_CYCLES = pdr_pkg::POR_HOLD_CYCLES
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        srst,
  // Software port
  input  wire logic [3:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic [15:0]      rdata,
  // Link to the device
  pdr_link_if.host         link
);
  typedef enum logic [1:0] {PDR_HS_RESET, PDR_HS_RECOV, PDR_HS_READY} pdr_hstate_t;

  initial begin
    if (POR_CYCLES < pdr_pkg::WARM_CYCLES || POR_CYCLES > 131071) $error("POR_CYCLES out of range");
  end

  pdr_hstate_t st_r;
  logic [16:0] cnt_r;
  logic        por_r;
  logic [15:0] bus_r, addr_low_r, sect_r, own_rdata_r;
  logic        strobe_r, fwd_rd_r;

  // Pass-through decode, only once the device is out of recovery
  wire ready   = (st_r == PDR_HS_READY);
  wire fwd     = !addr[3];
  wire own_wr  = wr && !fwd;
  wire cmd_wr  = own_wr && addr == pdr_pkg::H_CMD && ready;
  wire go_warm = cmd_wr && wdata[pdr_pkg::CMD_WARM];
  wire go_por  = cmd_wr && wdata[pdr_pkg::CMD_POR];

  // Reset pulse and recovery sequencer
  always_ff @(posedge clock) begin
    if (srst) begin
      st_r  <= PDR_HS_RESET;
      por_r <= 1'b1;
      cnt_r <= 17'(POR_CYCLES - 1);
    end else begin
      case (st_r)
        PDR_HS_RESET: if (cnt_r == 17'h0_0000) begin
                        st_r  <= PDR_HS_RECOV;
                        cnt_r <= 17'(pdr_pkg::RECOVERY_CYCLES - 1);
                      end else cnt_r <= cnt_r - 17'h0_0001;
        PDR_HS_RECOV: if (cnt_r == 17'h0_0000) begin
                        st_r  <= PDR_HS_READY;
                        por_r <= 1'b0;
                      end else cnt_r <= cnt_r - 17'h0_0001;
        PDR_HS_READY: if (go_por || go_warm) begin
                        st_r  <= PDR_HS_RESET;
                        por_r <= go_por;
                        cnt_r <= go_por ? 17'(POR_CYCLES - 1)
                                        : 17'(pdr_pkg::WARM_CYCLES - 1);
                      end
        default:      st_r <= PDR_HS_RESET;
      endcase
    end
  end

  // Own registers and the strobe generator
  always_ff @(posedge clock) begin
    if (srst) begin
      bus_r       <= pdr_pkg::BUS_RESET;
      addr_low_r  <= pdr_pkg::ZERO16;
      sect_r      <= pdr_pkg::ZERO16;
      strobe_r    <= 1'b0;
      own_rdata_r <= pdr_pkg::ZERO16;
      fwd_rd_r    <= 1'b0;
    end else begin
      if (own_wr && addr == pdr_pkg::H_BUS)  bus_r      <= wdata;
      if (own_wr && addr == pdr_pkg::H_ADDR) addr_low_r <= wdata;
      if (own_wr && addr == pdr_pkg::H_SECT) sect_r     <= wdata;
      strobe_r <= (ready && bus_r[pdr_pkg::BUS_RUN]) ? !strobe_r : strobe_r;
      fwd_rd_r <= rd && fwd;
      if (rd && addr == pdr_pkg::H_STATUS)
        own_rdata_r <= {12'h000, link.battery_active_indicator, link.power_down_flag,
                        ready, !ready};
      else if (rd && addr == pdr_pkg::H_BUS)
        own_rdata_r <= bus_r;
      else if (rd && addr == pdr_pkg::H_ADDR)
        own_rdata_r <= addr_low_r;
      else if (rd && addr == pdr_pkg::H_SECT)
        own_rdata_r <= sect_r;
      else
        own_rdata_r <= pdr_pkg::ZERO16;
    end
  end

  // Read data stands the cycle after the strobe
  assign rdata = fwd_rd_r ? link.reg_rdata : own_rdata_r;

  // Strobes, chip select and controls held idle until recovery ends, selects low during power-on
  assign link.rst_req                  = (st_r == PDR_HS_RESET);
  assign link.address_strobe_in        = strobe_r;
  assign link.chip_select_n            = ready ? bus_r[pdr_pkg::BUS_CS_N] : 1'b1;
  assign link.write_strobe_low_n       = !(ready && bus_r[pdr_pkg::BUS_WRL]);
  assign link.write_strobe_high_n      = !(ready && bus_r[pdr_pkg::BUS_WRH]);
  assign link.bus_control_1            = ready && bus_r[pdr_pkg::BUS_C1];
  assign link.bus_control_2            = ready && bus_r[pdr_pkg::BUS_C2];
  assign link.address_low              = addr_low_r[7:0];
  assign link.primary_sector_selects   = (ready || !por_r) ? sect_r[7:0] : 8'h00;
  assign link.secondary_sector_selects = (ready || !por_r) ? sect_r[11:8] : 4'h0;
  assign link.reg_addr                 = addr[2:0];
  assign link.reg_wdata                = wdata;
  assign link.reg_wr                   = wr && fwd && ready;
  assign link.reg_rd                   = rd && fwd && ready;
endmodule : pdr_host

// *** tb/pdr_monitor.sv ***
// Purpose: Link checks between the host and device ends
// Assumes: One clock, srst synchronous active high
// Notes:   Sees interface pins only, so register state is inferred
`timescale 1ns/100ps
module pdr_monitor (
  // Clock and reset
  input wire logic        clock,
  input wire logic        srst,
  // Link pins
  input wire logic        rst_req,
  input wire logic        address_strobe_in,
  input wire logic        chip_select_n,
  input wire logic        write_strobe_low_n,
  input wire logic [7:0]  primary_sector_selects,
  input wire logic [3:0]  secondary_sector_selects,
  input wire logic [2:0]  reg_addr,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic        power_down_flag,
  input wire logic        battery_active_indicator
);
  logic       por_r;
  logic       strobe_r;
  logic [4:0] idle_r;
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  // Power-on phase and idle run; idle saturates so it never wraps to a false low
  always_ff @(posedge clock) begin
    por_r    <= srst | (por_r & !$fell(rst_req));
    strobe_r <= address_strobe_in;
    idle_r   <= (srst | (address_strobe_in != strobe_r) | !chip_select_n | rst_req) ? 5'd0
              : idle_r + 5'(idle_r != 5'd31);
  end
  por_quiet_a: assert property (por_r && rst_req |-> write_strobe_low_n && primary_sector_selects == 8'h00
    && secondary_sector_selects == 4'h0) else $error("bus active during power-on reset");
  reset_width_a: assert property ($rose(rst_req) |-> rst_req[*8] ##1 rst_req[*7])
    else $error("reset pulse too short");
  recovery_quiet_a: assert property ($fell(rst_req) |-> (!reg_wr && !reg_rd)[*8] ##1 (!reg_wr && !reg_rd)[*4])
    else $error("access inside recovery");
  reset_block_a: assert property (rst_req |-> !reg_wr && !reg_rd) else $error("access during reset");
  pd_count_a: assert property ($rose(power_down_flag) |-> idle_r >= 5'd15) else $error("early power-down");
  pd_wake_a: assert property (power_down_flag && (!chip_select_n || rst_req || address_strobe_in != strobe_r)
    |=> !power_down_flag) else $error("no wake from power-down");
  pd_refuse_a: assert property (power_down_flag && reg_rd |=> reg_rdata == 16'h0000)
    else $error("read served in power-down");
  mode_c_mask_a: assert property (reg_rd && reg_addr == pdr_pkg::IDX_MODE_C
    |=> (reg_rdata & ~pdr_pkg::MODE_C_MASK) == 16'h0000) else $error("mode C spare bits set");
  batt_status_a: assert property (reg_rd && reg_addr == pdr_pkg::IDX_STATUS && !power_down_flag
    |=> reg_rdata[pdr_pkg::ST_BATT] == $past(battery_active_indicator)) else $error("battery status mismatch");
endmodule : pdr_monitor

// *** tb/tb.sv ***
// Purpose: Both ends joined, driven through the host software port
// Assumes: Short power-on hold and config load for run time
// Notes:   Bus control bit2 taken as write strobe asserted
`timescale 1ns/100ps
module tb;
  localparam logic [15:0] BUS_CFG = 16'h00CD;
  logic        clock = 1'b0;
  logic        srst = 1'b1;
  logic [3:0]  addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        vcc_low = 1'b0;
  logic        fdone = 1'b0;
  logic        armed = 1'b0;
  logic        fab_seen = 1'b0;
  logic        warm_bad = 1'b0;
  logic [15:0] v;
  logic [15:0] c;
  int          mismatches = 0;
  int          samples_checked = 0;
  wire  [15:0] rdata;
  wire  [15:0] bmode;
  wire  [11:0] msel;
  wire  [12:0] arr_in;
  wire         low_pwr, stby, and_en, mc_en, valid, mc_clr, mem_en, fbusy, fabort, gp_in, a_oe, d_oe, p_oe;
  pdr_link_if link ();
  pdr_host #(.POR_CYCLES(40)) pdr_host_inst (.clock(clock), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .link(link));
  pdr_device #(.BUS_MODE_CFG(BUS_CFG), .CFG_LOAD(4)) pdr_device_inst (.clock(clock), .srst(srst), .link(link),
    .vcc_below_standby(vcc_low), .flash_done(fdone), .logic_low_power(low_pwr), .logic_standby(stby),
    .clk_to_and_en(and_en), .clk_to_mc_en(mc_en), .logic_array_in(arr_in), .logic_outputs_valid(valid),
    .macrocell_clear(mc_clr), .memories_enable(mem_en), .memory_selects(msel), .flash_busy(fbusy),
    .flash_abort(fabort), .bus_mode_out(bmode), .gp_as_input(gp_in), .addr_out_oe(a_oe), .data_oe(d_oe),
    .periph_oe(p_oe));
  pdr_monitor pdr_monitor_inst (.clock(clock), .srst(srst), .rst_req(link.rst_req),
    .address_strobe_in(link.address_strobe_in), .chip_select_n(link.chip_select_n),
    .write_strobe_low_n(link.write_strobe_low_n), .primary_sector_selects(link.primary_sector_selects),
    .secondary_sector_selects(link.secondary_sector_selects), .reg_addr(link.reg_addr), .reg_wr(link.reg_wr),
    .reg_rd(link.reg_rd), .reg_rdata(link.reg_rdata), .power_down_flag(link.power_down_flag),
    .battery_active_indicator(link.battery_active_indicator));
  always #5 clock = ~clock;
  // Warm reset watch: abort pulse must show, outputs must stay valid
  always @(posedge clock) begin
    if (armed) begin
      fab_seen <= fab_seen | fabort;
      warm_bad <= warm_bad | !valid | mc_clr;
    end
  end
  function automatic logic [15:0] bus_exp(input logic [15:0] cfg);
    return cfg & 16'hFF77;
  endfunction : bus_exp
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick
  task automatic wreg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [3:0] a, output logic [15:0] d);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rreg
  task automatic rchk(input string what, input logic [3:0] a, input logic [15:0] exp);
    logic [15:0] d;
    rreg(a, d);
    chk(what, d, exp);
  endtask : rchk
  // Poll host status until the recovery wait is over
  task automatic wait_ready();
    logic [15:0] d;
    d = 16'h0000;
    for (int k = 0; k < 100 && d[1] !== 1'b1; k++) rreg(pdr_pkg::H_STATUS, d);
    chk("ready", {15'h0, d[1]}, 16'h0001);
  endtask : wait_ready
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim
  initial begin
    #200000;
    mismatches++;
    end_sim();
  end
  initial begin
    v = 16'($urandom(29785));
    repeat (6) @(posedge clock);
    srst <= 1'b0;
    wait_ready();
    rchk("mode_a", 4'h0, 16'h0000);
    rchk("bus_mode", 4'h3, bus_exp(BUS_CFG));
    chk("cfg", {14'h0, valid, mc_clr}, 16'h0002);
    chk("ports", {14'h0, gp_in, a_oe}, 16'h0001);
    chk("bus_mode_out", bmode, bus_exp(BUS_CFG));
    for (int i = 0; i < 5; i++) begin
      v = 16'($urandom) & 16'h0038;
      wreg(4'h0, v);
      tick(2);
      chk("array_ctl", {13'h0, low_pwr, and_en, mc_en}, {13'h0, v[3], !v[4], !v[5]});
    end
    wreg(4'h0, 16'h0008);
    tick(10);
    chk("standby", {15'h0, stby}, 16'h0001);
    c = 16'($urandom);
    wreg(4'h1, c);
    rchk("mode_c", 4'h1, c & pdr_pkg::MODE_C_MASK);
    wreg(pdr_pkg::H_SECT, 16'h0001);
    wreg(pdr_pkg::H_BUS, 16'h0000);
    tick(2);
    chk("mem_sel", {1'h0, p_oe, d_oe, mem_en, msel}, 16'h3001);
    // Idle pins: only write strobe high and low sit high; mode C blocks them
    chk("array_in", {3'h0, arr_in}, {3'h0, !c[6], 3'h0, !c[2], 8'h00});
    wreg(pdr_pkg::H_BUS, 16'h0004);
    tick(2);
    chk("flash_busy", {15'h0, fbusy}, 16'h0001);
    armed = 1'b1;
    wreg(pdr_pkg::H_CMD, 16'h0002);
    wait_ready();
    armed = 1'b0;
    chk("warm", {14'h0, fab_seen, warm_bad}, 16'h0002);
    wreg(pdr_pkg::H_BUS, 16'h0002);
    fdone <= 1'b1;
    tick(1);
    fdone <= 1'b0;
    tick(1);
    chk("flash_idle", {15'h0, fbusy}, 16'h0000);
    rchk("mode_a_keep", 4'h0, 16'h0008);
    rchk("mode_c_keep", 4'h1, c & pdr_pkg::MODE_C_MASK);
    rchk("bus_reload", 4'h3, bus_exp(BUS_CFG));
    wreg(4'h2, 16'h0000);
    wreg(4'h0, 16'h000A);
    tick(10);
    chk("pd_early", {15'h0, link.power_down_flag}, 16'h0000);
    tick(10);
    chk("pd_set", {13'h0, link.power_down_flag, mem_en, a_oe}, 16'h0004);
    rchk("pd_refuse", 4'h0, 16'h0000);
    wreg(pdr_pkg::H_BUS, 16'h0003);
    tick(2);
    chk("pd_wake", {15'h0, link.power_down_flag}, 16'h0000);
    vcc_low <= 1'b1;
    tick(5);
    chk("battery", {15'h0, link.battery_active_indicator}, 16'h0001);
    rchk("dev_status", 4'h4, 16'h000A);
    // A long link reset is still warm to the device: only a supply start clears mode A
    wreg(pdr_pkg::H_CMD, 16'h0001);
    wait_ready();
    rchk("por_cmd_keep", 4'h0, 16'h000A);
    @(posedge clock);
    srst <= 1'b1;
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    wait_ready();
    rchk("por_clear", 4'h0, 16'h0000);
    end_sim();
  end
endmodule : tb
